// ==== logic/counter_timer_host_port.sv ====
// Purpose: host register window into the counter/timer chip
// Assumes: host keeps rd and wr one cycle each, never together
// Notes: counter outputs come from pins and are synchronised
module counter_timer_host_port (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire ctr_port_pkg::bus_req_t BUS_IN,
  input wire logic [4:0] CTR_OUT_IN,
  input wire logic BYTE_ORDER_TOGGLE_IN,
  output logic [15:0] RDATA_OUT,
  output logic RVALID_OUT,
  output logic [4:0] SEL_OUT
);
  import ctr_port_pkg::*;

  // ****************************************
  // Assertion clocking
  // ****************************************
  default clocking chk_cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] s1_q, s2_q, s3_q, lvl_q;
  logic [5:0] lvl_d;
  logic [5:0] pin_raw;
  assign pin_raw = {CTR_OUT_IN, BYTE_ORDER_TOGGLE_IN};
  always_comb begin
    // A change counts once two stages agree, filtering single glitches
    for (int i = 0; i < 6; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      lvl_q <= 6'h00;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // ****************************************
  // Decode, selection and read data
  // ****************************************
  logic data_wr, data_rd, cmd_wr, stat_rd, sel_cmd;
  logic [SEL_W-1:0] sel_q, sel_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] int_rdata;
  logic [15:0] status_word;

  always_comb begin
    data_wr = 1'b0;
    data_rd = 1'b0;
    cmd_wr = 1'b0;
    stat_rd = 1'b0;
    if (BUS_IN.addr == DATA_OFS) begin
      data_wr = BUS_IN.wr;
      data_rd = BUS_IN.rd;
    end else if (BUS_IN.addr == CMD_OFS) begin
      cmd_wr = BUS_IN.wr;
      stat_rd = BUS_IN.rd;
    end
  end

  // Only well-formed commands that name a register move the selection
  assign sel_cmd = cmd_wr && BUS_IN.wdata[15:8] == CMD_UPPER
    && BUS_IN.wdata[7:0] >= SEL_CODE_FIRST
    && BUS_IN.wdata[7:0] <= SEL_CODE_LAST;

  // Undefined upper bits read zero so polling software sees a fixed value
  always_comb begin
    status_word = WORD_RESET;
    status_word[STAT_TOGGLE_BIT] = lvl_q[0];
    status_word[STAT_OUT_LSB +: NUM_CTRS] = lvl_q[5:1];
  end

  always_comb begin
    sel_d = sel_q;
    if (sel_cmd) begin
      sel_d = SEL_W'(BUS_IN.wdata[7:0] - SEL_CODE_FIRST);
    end
    rvalid_d = data_rd | stat_rd;
    rdata_d = WORD_RESET;
    if (data_rd) begin
      rdata_d = int_rdata;
    end else if (stat_rd) begin
      rdata_d = status_word;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      sel_q <= SEL_RESET;
      rdata_q <= WORD_RESET;
      rvalid_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ctr_regfile #(.DEPTH(NUM_INT_REGS), .AW(SEL_W)) u_regs (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .wr_in(data_wr),
    .sel_in(sel_q),
    .wdata_in(BUS_IN.wdata),
    .rdata_out(int_rdata)
  );

  assign RDATA_OUT = rdata_q;
  assign RVALID_OUT = rvalid_q;
  assign SEL_OUT = sel_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence sel_write_s;
    cmd_wr && BUS_IN.wdata == 16'hff05;
  endsequence

  sequence bad_upper_s;
    cmd_wr && BUS_IN.wdata[15:8] != CMD_UPPER;
  endsequence

  sequence bad_code_s;
    cmd_wr && BUS_IN.wdata[15:8] == CMD_UPPER
      && (BUS_IN.wdata[7:0] < SEL_CODE_FIRST
      || BUS_IN.wdata[7:0] > SEL_CODE_LAST);
  endsequence

  sequence data_write_s;
    data_wr;
  endsequence

  sequence data_read_s;
    data_rd && !cmd_wr;
  endsequence

  sequence any_read_s;
    data_rd || stat_rd;
  endsequence

  // Four steady samples cover the three-stage pipe and the agree test
  sequence pins_steady_s;
    $stable(pin_raw) [*4];
  endsequence

  sel_hold_a: assert property (
    !sel_cmd |=> sel_q == $past(sel_q))
    else $error("selection changed without command");

  sel_take_a: assert property (
    sel_write_s |=> sel_q == 5'h04)
    else $error("selection not taken");

  bad_cmd_a: assert property (
    bad_upper_s |=> $stable(sel_q))
    else $error("malformed command moved selection");

  bad_code_a: assert property (
    bad_code_s |=> $stable(sel_q))
    else $error("non-selecting code moved selection");

  sel_code_a: assert property (
    sel_cmd |=> 8'(sel_q) + 8'h01 == $past(BUS_IN.wdata[7:0]))
    else $error("selection does not match command code");

  sel_range_a: assert property (
    sel_q < 5'h12)
    else $error("selection out of range");

  stat_read_a: assert property (
    stat_rd |=> RVALID_OUT && RDATA_OUT[15:6] == 10'h000)
    else $error("status read wrong");

  stat_out_a: assert property (
    stat_rd |=> RDATA_OUT[5:1] == $past(lvl_q[5:1]))
    else $error("counter outputs not reported");

  stat_toggle_a: assert property (
    stat_rd |=> RDATA_OUT[0] == $past(lvl_q[0]))
    else $error("toggle flag not reported");

  data_rw_a: assert property (
    data_write_s ##1 data_read_s |=> RDATA_OUT == $past(BUS_IN.wdata, 2))
    else $error("data port readback wrong");

  whole_word_a: assert property (
    data_rd |=> RVALID_OUT && RDATA_OUT == $past(int_rdata))
    else $error("partial word on data port");

  read_valid_a: assert property (
    any_read_s |=> RVALID_OUT)
    else $error("read not answered");

  idle_out_a: assert property (
    !(data_rd || stat_rd) |=> !RVALID_OUT && RDATA_OUT == WORD_RESET)
    else $error("answer without read");

  cmd_side_a: assert property (
    cmd_wr |=> $changed(sel_q) || $stable(int_rdata))
    else $error("command write reached register file");

  stat_quiet_a: assert property (
    stat_rd |=> $stable(sel_q) && $stable(int_rdata))
    else $error("status read had a side effect");

  sync_take_a: assert property (
    s2_q == s3_q |=> lvl_q == $past(s3_q))
    else $error("agreed pin level not taken");

  sync_hold_a: assert property (
    s2_q != s3_q |=> lvl_q == $past(lvl_q))
    else $error("pin level moved before stages agreed");

  pin_level_a: assert property (
    pins_steady_s |=> lvl_q == $past(pin_raw))
    else $error("steady pin level not reflected");
endmodule

// ==== include/ctr_port_pkg.sv ====
// Purpose: constants and types for the counter/timer host port
// Assumes: 16-bit board bus, byte offsets from the board base
// Notes: the counter chip's internal register contents are opaque here
package ctr_port_pkg;
  // ****************************************
  // Offsets and layout
  // ****************************************
  localparam logic [4:0] DATA_OFS = 5'h14;
  localparam logic [4:0] CMD_OFS = 5'h16;
  localparam int NUM_INT_REGS = 18;
  localparam int NUM_CTRS = 5;
  localparam int SEL_W = 5;
  localparam logic [7:0] CMD_UPPER = 8'hff;
  localparam int STAT_OUT_LSB = 1;
  localparam int STAT_TOGGLE_BIT = 0;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Command codes 0x01..0x12 select internal register (code-1)
  localparam logic [7:0] SEL_CODE_FIRST = 8'h01;
  localparam logic [7:0] SEL_CODE_LAST = 8'h12;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } bus_req_t;
endpackage

// ==== logic/ctr_regfile.sv ====
// Purpose: internal register file of the counter chip
// Assumes: selection index already range checked
// Notes: contents are plain storage; counting lives elsewhere
module ctr_regfile #(
  parameter int DEPTH = 18,
  parameter int AW = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [AW-1:0] sel_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  import ctr_port_pkg::*;
  logic [15:0] mem_q [DEPTH];
  logic [15:0] mem_d [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_in) begin
      mem_d[sel_in] = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_q[i] <= rst_in ? WORD_RESET : mem_d[i];
    end
  end

  assign rdata_out = mem_q[sel_in];
endmodule

// ==== test/host_model.sv ====
// Purpose: host processor model for the counter port
// Assumes: one whole 16-bit word per access
// Notes: request changes only at falling edges
module host_model (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [15:0] rdata_in,
  output ctr_port_pkg::bus_req_t bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ctr_port_pkg::*;
  initial bus_out = '0;
  // ****
  // One access, answer taken a cycle later
  // ****
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d, output logic [16:0] q);
    @(negedge clk_in);
    bus_out = '{!w, w, a, d};
    @(negedge clk_in);
    q = {rvalid_in, rdata_in};
    // Idle bus shows inverted values so stale data cannot pass
    bus_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // ****
  // Write then read on adjacent cycles, answer taken after the read
  // ****
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] d,
                       output logic [16:0] q);
    @(negedge clk_in);
    bus_out = '{1'b0, 1'b1, a, d};
    @(negedge clk_in);
    bus_out = '{1'b1, 1'b0, a, ~d};
    @(negedge clk_in);
    q = {rvalid_in, rdata_in};
    bus_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// ==== test/counter_timer_host_port_tb.sv ====
// Purpose: self-checking bench for the counter port
// Assumes: status pins settle within five cycles
// Notes: status bits 15..6 are masked
module counter_timer_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ctr_port_pkg::*;
  logic mclk, rst, tog, rvalid;
  logic [4:0] ctr, sel;
  logic [15:0] rdata;
  logic [15:0] mem [NUM_INT_REGS];
  logic [16:0] got;
  bus_req_t bus;
  int bad_count, checked, seed, cyc, i;
  counter_timer_host_port u_counter_timer_host_port (
    .MCLK_IN(mclk), .RST_IN(rst), .BUS_IN(bus), .CTR_OUT_IN(ctr),
    .BYTE_ORDER_TOGGLE_IN(tog), .RDATA_OUT(rdata),
    .RVALID_OUT(rvalid), .SEL_OUT(sel));
  host_model u_host_model (.clk_in(mclk), .rvalid_in(rvalid),
    .rdata_in(rdata), .bus_out(bus));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ****
  // Checks and verdict
  // ****
  task automatic chk(input string n, input logic [16:0] e, a);
    checked++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, a);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [16:0] stat(input logic [4:0] c, input logic t);
    return {1'b1, 10'h000, c, t};
  endfunction
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    seed = 40;
    rst = 1'b1;
    ctr = 5'h00;
    tog = 1'b0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk("sel_rst", 17'h00000, 17'(sel));
    for (i = 0; i < NUM_INT_REGS; i++) begin
      u_host_model.xfer(1, CMD_OFS, {CMD_UPPER, 8'(i + 1)}, got);
      chk("sel", 17'(i), 17'(sel));
      mem[i] = 16'($random(seed));
      u_host_model.xfer(1, DATA_OFS, mem[i], got);
    end
    // Reverse order, with noise between select and read
    for (i = NUM_INT_REGS - 1; i >= 0; i--) begin
      u_host_model.xfer(1, CMD_OFS, {CMD_UPPER, 8'(i + 1)}, got);
      u_host_model.xfer(0, 5'h10, 16'h0000, got);
      chk("unmapped", 17'h00000, {got[16], 16'h0000});
      u_host_model.xfer(1, CMD_OFS, 16'h0003, got);
      u_host_model.xfer(0, DATA_OFS, 16'h0000, got);
      chk("data", {1'b1, mem[i]}, got);
    end
    // Write and read on adjacent cycles, random register each time
    repeat (8) begin
      i = {$random(seed)} % NUM_INT_REGS;
      u_host_model.xfer(1, CMD_OFS, {CMD_UPPER, 8'(i + 1)}, got);
      mem[i] = 16'($random(seed));
      u_host_model.wr_rd(DATA_OFS, mem[i], got);
      chk("wr_rd", {1'b1, mem[i]}, got);
    end
    // Codes outside the selecting range leave the selection alone
    u_host_model.xfer(1, CMD_OFS, 16'hff13, got);
    u_host_model.xfer(1, CMD_OFS, 16'hff00, got);
    chk("sel_keep", 17'(i), 17'(sel));
    repeat (6) begin
      ctr = 5'($random(seed));
      tog = 1'($random(seed));
      repeat (5) @(negedge mclk);
      u_host_model.xfer(0, CMD_OFS, 16'h0000, got);
      chk("status", stat(ctr, tog), got & 17'h1003f);
    end
    give_verdict();
  end
endmodule
